/* File: pkg/cmc_cfg.svh */
// constants of the can mode control block: offsets, bit positions,
// reset values and timing counts
// assumes a 250 MHz hclk and byte-wide registers on word addresses
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

// ====================================
// register byte offsets (haddr[7:0])
`define CMC_OFF_CTL0  8'h00
`define CMC_OFF_MODE  8'h04
`define CMC_OFF_BTA   8'h08
`define CMC_OFF_BTB   8'h0C
`define CMC_OFF_ACC   8'h10
`define CMC_OFF_RFLG  8'h14
`define CMC_OFF_RIER  8'h18
`define CMC_OFF_CODE  8'h20
`define CMC_OFF_MASK  8'h40

// ====================================
// first_control_reg bit positions
`define CMC_C0_INIT   0
`define CMC_C0_SLEEP  1
`define CMC_C0_WAKE   2
`define CMC_C0_TIMER  3
`define CMC_C0_SYNC   4
`define CMC_C0_WSTOP  5

// ====================================
// mode_control_reg bit positions
`define CMC_MC_INIT_ACK 0
`define CMC_MC_SLEEP_ACK  1
`define CMC_MC_WFILT  2
`define CMC_MC_BUSOFF_RECOVERY_POLICY   3
`define CMC_MC_LISTEN 4
`define CMC_MC_LOOP   5
`define CMC_MC_CLK    6
`define CMC_MC_ENA    7

// ====================================
// flag and irq enable bit positions
`define CMC_RF_WAKE   7
`define CMC_RF_RST_HI 5
`define CMC_RF_TST_HI 3
`define CMC_RI_WAKE   7

// ====================================
// reset values
`define CMC_RST_BYTE  8'h00
`define CMC_RST_INIT  1'b1

// ====================================
// timing
`define CMC_CLK_MHZ     250
`define CMC_WUP_NS      2000
`define CMC_WUP_CYC     ((`CMC_WUP_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_IDLE_BITS   11
`define CMC_BUSOFF_RUNS 128

`endif

/* File: pkg/cmc_pkg.sv */
// types shared by the can mode control block
// assumes cmc_cfg.svh holds all numeric constants
package cmc_pkg;
  typedef logic [7:0]  cmc_byte_t;
  typedef logic [31:0] cmc_word_t;
  // controller operating mode; acks are decoded from it
  typedef enum logic [1:0] {
    CMC_RUN,
    CMC_INIT,
    CMC_SLEEP
  } cmc_mode_t;
endpackage

/* File: pkg/cmc_mon_if.sv */
// link between mode control and the bus monitor
// assumes both ends run on hclk
`timescale 1ns/1ps
`default_nettype none
interface cmc_mon_if;
  logic restart;     // hold resync counter in reset while init is requested
  logic bus_off;     // protocol engine is bus-off
  logic rx_bit;      // receive stream as the engine sees it
  logic bit_tick;    // one pulse per sampled bit
  logic bus_rx;      // raw receive pin for wake detection
  logic wake_arm;    // sleeping with wake enabled
  logic filter_mode; // 1 = require long dominant pulse
  logic synced;      // resynchronised to the bus
  logic wake_hit;    // one-cycle wake event
  modport ctl (output restart, bus_off, rx_bit, bit_tick, bus_rx,
               wake_arm, filter_mode, input synced, wake_hit);
  modport mon (input restart, bus_off, rx_bit, bit_tick, bus_rx,
               wake_arm, filter_mode, output synced, wake_hit);
endinterface
`default_nettype wire

/* File: design/cmc_bus_monitor.sv */
// bus monitor: recessive-run resync counter and wake-up filter
// assumes bit_tick comes from the bit timing logic on hclk
`include "cmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_monitor (
  input  wire logic hclk,
  input  wire logic hresetn,
  cmc_mon_if.mon    mon
);
  import cmc_pkg::*;

  localparam logic [3:0]  RUN_LAST = 4'(`CMC_IDLE_BITS - 1);
  localparam logic [6:0]  OCC_LAST = 7'(`CMC_BUSOFF_RUNS - 1);
  localparam logic [9:0]  WUP_LAST = 10'(`CMC_WUP_CYC - 1);

  logic [3:0] run_reg;  // consecutive recessive bits seen
  logic [6:0] occ_reg;  // completed runs while bus-off
  logic       sync_reg; // resynchronised
  logic [9:0] dom_reg;  // dominant cycles while armed
  wire        run_done = mon.bit_tick && mon.rx_bit && run_reg == RUN_LAST;
  wire        dominant = mon.wake_arm && !mon.bus_rx;

  // ====================================
  // resync after idle runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg  <= '0;
      occ_reg  <= '0;
      sync_reg <= 1'b0;
    end else if (mon.restart || sync_reg) begin
      run_reg  <= '0;
      occ_reg  <= '0;
      sync_reg <= sync_reg && !mon.restart;
    end else if (mon.bit_tick && !mon.rx_bit) begin
      run_reg  <= '0;                  // dominant bit breaks the run
    end else if (run_done) begin
      run_reg  <= '0;
      // bus-off needs many runs before joining again
      sync_reg <= !mon.bus_off || occ_reg == OCC_LAST;
      occ_reg  <= occ_reg + 7'd1;
    end else if (mon.bit_tick) begin
      run_reg  <= run_reg + 4'd1;
    end
  end

  // ====================================
  // wake filter: counts dominant hclk cycles while armed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dom_reg <= '0;
    end else if (!dominant) begin
      dom_reg <= '0;
    end else if (dom_reg != WUP_LAST) begin
      dom_reg <= dom_reg + 10'd1;
    end
  end

  assign mon.synced   = sync_reg;
  // unfiltered wakes on any dominant level, filtered needs the min time
  assign mon.wake_hit = dominant && (!mon.filter_mode || dom_reg == WUP_LAST);
endmodule
`default_nettype wire

/* File: design/cmc_mode_ctrl.sv */
// can mode control: mode handshakes, write protection, tx pin safety,
// loopback/listen steering and an ahb-lite register slave
// assumes a protocol engine and bit timing logic beside it on hclk
`include "cmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_ctrl (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire cmc_pkg::cmc_word_t haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire cmc_pkg::cmc_word_t hwdata,
  output var  cmc_pkg::cmc_word_t hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // system and engine status
  input  wire logic             cpu_stop,
  input  wire logic             cpu_wait,
  input  wire logic             special_mode,
  input  wire logic             rx_frame_busy,
  input  wire logic             tx_buffers_empty,
  input  wire logic             engine_tx_bit,
  input  wire logic             bit_tick,
  input  wire logic             bus_off,
  input  wire logic [1:0]       tx_error_state,
  input  wire logic [1:0]       rx_error_state,
  // bus pins
  input  wire logic             bus_rx_pin,
  output logic                  bus_tx_pin,
  // engine steering
  output logic                  engine_rx_bit,
  output logic                  engine_abort,
  output logic                  tx_inhibit,
  output logic                  ignore_ack_slot,
  output logic                  suppress_ack_error,
  output logic                  freeze_error_counters,
  output logic                  bus_synced,
  output logic                  controller_enable,
  output logic                  clock_source_select,
  output logic                  busoff_recovery_policy,
  output logic                  timer_enable,
  output var  cmc_pkg::cmc_byte_t bit_timing_a,
  output var  cmc_pkg::cmc_byte_t bit_timing_b,
  output var  cmc_pkg::cmc_byte_t acceptance_control,
  output logic [63:0]           acceptance_codes,
  output logic [63:0]           acceptance_masks
);
  import cmc_pkg::*;

  // ====================================
  // address helpers
  // true when a byte address hits a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // true when a byte address falls in an 8-word bank
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a[7:5] == base[7:5]);
  endfunction

  // ====================================
  // state
  cmc_mode_t mode_reg;          // run, init or sleep
  cmc_mode_t mode_next;         // next mode
  logic      init_req_reg;      // init request bit
  logic      sleep_req_reg;     // sleep request bit
  logic      wake_en_reg;       // wake enable
  logic      wstop_reg;         // stop controller in wait
  logic      timer_reg;         // timestamp timer enable
  logic      ena_reg;           // controller enable
  logic      ena_lock_reg;      // enable already written once
  logic      clk_sel_reg;       // clock source select
  logic      loop_reg;          // loopback self test
  logic      listen_reg;        // monitor only
  logic      busoff_recovery_policy_reg;          // bus-off recovery policy
  logic      wfilt_reg;         // wake filter mode
  logic      wake_flag_reg;     // sticky wake flag
  logic      wake_ie_reg;       // wake irq enable
  cmc_byte_t bta_reg;           // bit timing a
  cmc_byte_t btb_reg;           // bit timing b
  cmc_byte_t acc_reg;           // acceptance control
  cmc_byte_t code_reg [0:7];    // acceptance codes
  cmc_byte_t mask_reg [0:7];    // acceptance masks

  // bus slave state
  logic      wr_pend_reg;       // write data phase
  logic      rd_pend_reg;       // read wait cycle
  logic [7:0] ap_addr_reg;      // latched address
  cmc_byte_t hrdata_reg;        // read data flop
  cmc_byte_t rd_byte;           // read mux

  cmc_mon_if mon_if ();

  // ====================================
  // mode decode
  wire init_mode  = (mode_reg == CMC_INIT) && init_req_reg;
  wire sleep_mode = (mode_reg == CMC_SLEEP) && sleep_req_reg;
  wire init_ack   = (mode_reg == CMC_INIT);
  wire sleep_ack  = (mode_reg == CMC_SLEEP);
  wire bus_idle   = !rx_frame_busy && tx_buffers_empty;
  // hold starts on the entry edge so that no read in init sees stale bits
  wire c0_hold    = init_ack || (mode_next == CMC_INIT);
  wire wake_hit   = mon_if.wake_hit;

  // ====================================
  // bus decode
  wire       take   = hsel && hready && htrans[1];
  wire [7:0] wdata  = hwdata[7:0];
  wire       wr_c0  = wr_pend_reg && hit(ap_addr_reg, `CMC_OFF_CTL0);
  wire       wr_mc  = wr_pend_reg && hit(ap_addr_reg, `CMC_OFF_MODE);
  wire       wr_bta = wr_pend_reg && hit(ap_addr_reg, `CMC_OFF_BTA);
  wire       wr_btb = wr_pend_reg && hit(ap_addr_reg, `CMC_OFF_BTB);
  wire       wr_acc = wr_pend_reg && hit(ap_addr_reg, `CMC_OFF_ACC);
  wire       wr_rf  = wr_pend_reg && hit(ap_addr_reg, `CMC_OFF_RFLG);
  wire       wr_ri  = wr_pend_reg && hit(ap_addr_reg, `CMC_OFF_RIER);
  wire       wr_cd  = wr_pend_reg && in_bank(ap_addr_reg, `CMC_OFF_CODE);
  wire       wr_mk  = wr_pend_reg && in_bank(ap_addr_reg, `CMC_OFF_MASK);
  wire [2:0] bank_i = ap_addr_reg[4:2];
  // config writes only land in init mode; others are dropped silently
  wire       cfg_ok = init_mode;

  // ====================================
  // mode sequencer
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      CMC_INIT: begin
        if (!init_req_reg) begin
          mode_next = CMC_RUN;
        end
      end
      CMC_RUN: begin
        if (init_req_reg) begin
          mode_next = CMC_INIT;
        end else if (sleep_req_reg && bus_idle) begin
          mode_next = CMC_SLEEP;
        end
      end
      default: begin
        if (init_req_reg) begin
          mode_next = CMC_INIT;
        end else if (!sleep_req_reg || wake_hit) begin
          mode_next = CMC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= CMC_INIT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ====================================
  // request bits: clears refused until the mode is reached
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_req_reg  <= `CMC_RST_INIT;
      sleep_req_reg <= 1'b0;
    end else begin
      if (wr_c0 && (wdata[`CMC_C0_INIT] || init_mode)) begin
        init_req_reg <= wdata[`CMC_C0_INIT];
      end
      // a set cannot happen while a wake is pending
      if (wr_c0 && wdata[`CMC_C0_SLEEP] && !wake_flag_reg) begin
        sleep_req_reg <= 1'b1;                // set wins over wake clear
      end else if (sleep_mode && wake_hit) begin
        sleep_req_reg <= 1'b0;
      end else if (wr_c0 && !wdata[`CMC_C0_SLEEP] && sleep_mode) begin
        sleep_req_reg <= 1'b0;
      end
    end
  end

  // ====================================
  // other first-control bits; held at reset in init except wake enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_en_reg <= 1'b0;
      wstop_reg   <= 1'b0;
      timer_reg   <= 1'b0;
    end else if (c0_hold) begin
      wstop_reg   <= 1'b0;
      timer_reg   <= 1'b0;
      if (wr_c0) begin
        wake_en_reg <= wdata[`CMC_C0_WAKE];
      end
    end else if (wr_c0) begin
      wake_en_reg <= wdata[`CMC_C0_WAKE];
      wstop_reg   <= wdata[`CMC_C0_WSTOP];
      timer_reg   <= wdata[`CMC_C0_TIMER];
    end
  end

  // ====================================
  // mode control register, writable in init only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel_reg <= 1'b0;
      loop_reg    <= 1'b0;
      listen_reg  <= 1'b0;
      busoff_recovery_policy_reg    <= 1'b0;
      wfilt_reg   <= 1'b0;
    end else if (wr_mc && cfg_ok) begin
      clk_sel_reg <= wdata[`CMC_MC_CLK];
      loop_reg    <= wdata[`CMC_MC_LOOP];
      listen_reg  <= wdata[`CMC_MC_LISTEN];
      busoff_recovery_policy_reg    <= wdata[`CMC_MC_BUSOFF_RECOVERY_POLICY];
      wfilt_reg   <= wdata[`CMC_MC_WFILT];
    end
  end

  // enable: once in normal system mode, freely in special mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ena_reg      <= 1'b0;
      ena_lock_reg <= 1'b0;
    end else if (wr_mc && cfg_ok && (special_mode || !ena_lock_reg)) begin
      ena_reg      <= wdata[`CMC_MC_ENA];
      ena_lock_reg <= !special_mode;
    end
  end

  // ====================================
  // timing and acceptance registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bta_reg <= `CMC_RST_BYTE;
      btb_reg <= `CMC_RST_BYTE;
      acc_reg <= `CMC_RST_BYTE;
    end else if (cfg_ok) begin
      if (wr_bta) begin
        bta_reg <= wdata;
      end
      if (wr_btb) begin
        btb_reg <= wdata;
      end
      if (wr_acc) begin
        acc_reg <= wdata;
      end
    end
  end

  // acceptance banks; no reset needed beyond a known start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) begin
        code_reg[i] <= `CMC_RST_BYTE;
        mask_reg[i] <= `CMC_RST_BYTE;
      end
    end else if (cfg_ok) begin
      if (wr_cd) begin
        code_reg[bank_i] <= wdata;
      end
      if (wr_mk) begin
        mask_reg[bank_i] <= wdata;
      end
    end
  end

  // ====================================
  // wake flag and irq enable; reset while init, error fields live
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_flag_reg <= 1'b0;
      wake_ie_reg   <= 1'b0;
    end else if (init_mode) begin
      wake_flag_reg <= 1'b0;
      wake_ie_reg   <= 1'b0;
    end else begin
      // a wake in the clearing cycle is kept
      if (wake_hit) begin
        wake_flag_reg <= 1'b1;
      end else if (wr_rf && wdata[`CMC_RF_WAKE]) begin
        wake_flag_reg <= 1'b0;
      end
      if (wr_ri) begin
        wake_ie_reg <= wdata[`CMC_RI_WAKE];
      end
    end
  end

  // ====================================
  // read mux
  always_comb begin
    rd_byte = `CMC_RST_BYTE;
    if (hit(ap_addr_reg, `CMC_OFF_CTL0)) begin
      rd_byte[`CMC_C0_INIT]  = init_req_reg;
      rd_byte[`CMC_C0_SLEEP] = sleep_req_reg;
      rd_byte[`CMC_C0_WAKE]  = wake_en_reg;
      rd_byte[`CMC_C0_TIMER] = timer_reg;
      rd_byte[`CMC_C0_SYNC]  = mon_if.synced;
      rd_byte[`CMC_C0_WSTOP] = wstop_reg;
    end else if (hit(ap_addr_reg, `CMC_OFF_MODE)) begin
      rd_byte = {ena_reg, clk_sel_reg, loop_reg, listen_reg,
                 busoff_recovery_policy_reg, wfilt_reg, sleep_ack, init_ack};
    end else if (hit(ap_addr_reg, `CMC_OFF_BTA)) begin
      rd_byte = bta_reg;
    end else if (hit(ap_addr_reg, `CMC_OFF_BTB)) begin
      rd_byte = btb_reg;
    end else if (hit(ap_addr_reg, `CMC_OFF_ACC)) begin
      rd_byte = acc_reg;
    end else if (hit(ap_addr_reg, `CMC_OFF_RFLG)) begin
      rd_byte[`CMC_RF_WAKE] = wake_flag_reg;
      rd_byte[`CMC_RF_RST_HI -: 2] = rx_error_state;
      rd_byte[`CMC_RF_TST_HI -: 2] = tx_error_state;
    end else if (hit(ap_addr_reg, `CMC_OFF_RIER)) begin
      rd_byte[`CMC_RI_WAKE] = wake_ie_reg;
    end else if (in_bank(ap_addr_reg, `CMC_OFF_CODE)) begin
      rd_byte = code_reg[bank_i];
    end else if (in_bank(ap_addr_reg, `CMC_OFF_MASK)) begin
      rd_byte = mask_reg[bank_i];
    end
  end

  // ====================================
  // ahb-lite slave: writes zero-wait, reads one wait so that a read
  // right after a write still returns the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take) begin
        ap_addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= `CMC_RST_BYTE;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rd_byte;
    end
  end

  assign hrdata    = {24'h00_0000, hrdata_reg};
  assign hreadyout = !rd_pend_reg;
  assign hresp     = 1'b0;

  // ====================================
  // bus monitor
  assign mon_if.restart     = init_req_reg;
  assign mon_if.bus_off     = bus_off;
  assign mon_if.rx_bit      = engine_rx_bit;
  assign mon_if.bit_tick    = bit_tick;
  assign mon_if.bus_rx      = bus_rx_pin;
  assign mon_if.wake_arm    = sleep_mode && wake_en_reg;
  assign mon_if.filter_mode = wfilt_reg;

  cmc_bus_monitor u_mon (
    .hclk    (hclk),
    .hresetn (hresetn),
    .mon     (mon_if)
  );

  // ====================================
  // pin safety: forcing is combinational so it acts in the same cycle
  wire stop_force = cpu_stop || (cpu_wait && wstop_reg);
  wire tx_force   = stop_force || init_req_reg
                 || loop_reg || listen_reg || !ena_reg || sleep_ack;

  assign bus_tx_pin    = tx_force ? 1'b1 : engine_tx_bit;
  assign engine_rx_bit = loop_reg ? engine_tx_bit : bus_rx_pin;

  // ====================================
  // engine steering
  assign engine_abort           = init_req_reg;
  assign tx_inhibit             = listen_reg || init_req_reg;
  assign ignore_ack_slot        = loop_reg;
  assign suppress_ack_error     = listen_reg;
  assign freeze_error_counters  = listen_reg;
  assign bus_synced             = mon_if.synced;
  assign controller_enable      = ena_reg;
  assign clock_source_select    = clk_sel_reg;
  assign busoff_recovery_policy = busoff_recovery_policy_reg;
  assign timer_enable           = timer_reg;
  assign bit_timing_a           = bta_reg;
  assign bit_timing_b           = btb_reg;
  assign acceptance_control     = acc_reg;

  // pack acceptance banks, bank 0 in the low byte
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      acceptance_codes[i*8 +: 8] = code_reg[i];
      acceptance_masks[i*8 +: 8] = mask_reg[i];
    end
  end

  // hsize is accepted but only whole-word transfers are expected
  wire unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8], wake_ie_reg};
endmodule
`default_nettype wire

/* File: tb/cmc_bus_node.sv */
// far-side bus node: receive pin level and a steady bit beat
// assumes it shares hclk and hresetn with the controller
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic dom,  // bench asks for a dominant bus
  output logic      rx,   // receive pin, idles recessive
  output logic      tick  // one pulse each fourth cycle
);
  logic [1:0] div_reg;    // bit period divider
  // ==========
  // beat runs free so recessive runs can be counted anytime
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 2'h0;
      tick <= 1'b0;
      rx <= 1'b1;
    end else begin
      div_reg <= div_reg + 2'h1;
      tick <= (div_reg == 2'h3);
      rx <= !dom;
    end
  end
endmodule
`default_nettype wire

/* File: tb/cmc_mode_ctrl_assertions.sv */
// pin and bus timing checks of cmc_mode_ctrl
// assumes one hclk domain; bound to every instance
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       cpu_stop,
  input wire logic       bus_rx_pin,
  input wire logic       bus_tx_pin,
  input wire logic       engine_tx_bit,
  input wire logic       engine_rx_bit,
  input wire logic       engine_abort,
  input wire logic       tx_inhibit,
  input wire logic       ignore_ack_slot,
  input wire logic       suppress_ack_error,
  input wire logic       freeze_error_counters,
  input wire logic       bus_synced,
  input wire logic       controller_enable
);
  // ==========
  // all checks on hclk, quiet while reset holds
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_STOP: assert property (cpu_stop |-> bus_tx_pin) else $error("tx live in stop");
  AST_INIT: assert property (engine_abort |-> bus_tx_pin && tx_inhibit) else $error("tx live in init");
  AST_LOOP: assert property (ignore_ack_slot |-> engine_rx_bit == engine_tx_bit && bus_tx_pin)
    else $error("loopback path wrong");
  AST_RXP: assert property (!ignore_ack_slot |-> engine_rx_bit == bus_rx_pin) else $error("rx path wrong");
  AST_LSTN: assert property (freeze_error_counters |-> suppress_ack_error && tx_inhibit && bus_tx_pin)
    else $error("listen leaks");
  AST_ENA: assert property (!controller_enable |-> bus_tx_pin) else $error("tx live when off");
  AST_SYNC: assert property ($rose(engine_abort) |=> !bus_synced) else $error("sync kept");
  AST_RD: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
endmodule
bind cmc_mode_ctrl cmc_mode_ctrl_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .cpu_stop, .bus_rx_pin, .bus_tx_pin, .engine_tx_bit, .engine_rx_bit, .engine_abort, .tx_inhibit,
  .ignore_ack_slot, .suppress_ack_error, .freeze_error_counters, .bus_synced, .controller_enable);
`default_nettype wire

/* File: tb/tb_cmc_mode_ctrl.sv */
// bench for cmc_mode_ctrl: ahb-lite tasks, then call sequences
// assumes cmc_bus_node stands on the bus side
`include "cmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_cmc_mode_ctrl;
  import cmc_pkg::*;
  logic      hclk, hresetn, hsel, hwrite, cpu_stop, special_mode, rx_frame_busy, engine_tx_bit, dom, rdy_s;
  logic [1:0] htrans, tx_error_state;
  cmc_word_t haddr, hwdata, rd_s;
  wire logic rdy, bus_rx_pin, bit_tick, bus_tx_pin, bus_synced, controller_enable, clock_source_select;
  wire logic ignore_ack_slot, busoff_recovery_policy;
  wire cmc_word_t hrdata;
  int        miscompares, checked;
  cmc_mode_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(rdy), .hwdata,
    .hrdata, .hreadyout(rdy), .hresp(), .cpu_stop, .cpu_wait(1'b0), .special_mode, .rx_frame_busy,
    .tx_buffers_empty(1'b1), .engine_tx_bit, .bit_tick, .bus_off(1'b0), .tx_error_state,
    .rx_error_state(2'h0), .bus_rx_pin, .bus_tx_pin, .engine_rx_bit(), .engine_abort(), .tx_inhibit(),
    .ignore_ack_slot, .suppress_ack_error(), .freeze_error_counters(), .bus_synced, .controller_enable,
    .clock_source_select, .busoff_recovery_policy, .timer_enable(), .bit_timing_a(), .bit_timing_b(),
    .acceptance_control(), .acceptance_codes(), .acceptance_masks());
  cmc_bus_node node (.hclk, .hresetn, .dom, .rx(bus_rx_pin), .tick(bit_tick));
  // ==========
  // ready and data as seen at the edge, free of update races
  always @(posedge hclk) begin
    rdy_s <= rdy;
    rd_s <= hrdata;
  end
  task automatic chk(input cmc_word_t g, input cmc_word_t e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one single transfer; holds each phase until ready is seen high
  task automatic xfer(input cmc_byte_t a, input logic w, input cmc_word_t d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge hclk); #1; end while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); #1; end while (rdy_s !== 1'b1);
  endtask
  task automatic wr(input cmc_byte_t a, input cmc_byte_t d);
    xfer(a, 1'b1, 32'(d));
  endtask
  task automatic rd(input cmc_byte_t a, input cmc_byte_t e);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rd_s, 32'(e));
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge hclk);
    miscompares++;
    conclude();
  end
  initial begin
    {hresetn, hsel, hwrite, cpu_stop, special_mode, rx_frame_busy, htrans, haddr, hwdata} = '0;
    {engine_tx_bit, dom, tx_error_state, miscompares, checked} = {1'b1, 1'b1, 2'h2, 64'h0};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    rd(`CMC_OFF_MODE, 8'h01);
    rd(`CMC_OFF_CTL0, 8'h01);
    rd(8'hFC, 8'h00);
    wr(`CMC_OFF_MODE, 8'hB8);
    rd(`CMC_OFF_MODE, 8'hB9);
    chk(32'(ignore_ack_slot), 1);
    chk(32'(busoff_recovery_policy), 1);
    wr(`CMC_OFF_MODE, 8'h00);
    rd(`CMC_OFF_MODE, 8'h81);
    special_mode <= 1'b1;
    wr(`CMC_OFF_MODE, 8'hC0);
    rd(`CMC_OFF_MODE, 8'hC1);
    chk(32'(clock_source_select), 1);
    wr(`CMC_OFF_BTA, 8'h5A);
    rd(`CMC_OFF_BTA, 8'h5A);
    rd(`CMC_OFF_RFLG, 8'h08);
    wr(`CMC_OFF_CTL0, 8'h00);
    dom <= 1'b0;
    repeat (40) @(posedge hclk);
    #1;
    chk(32'(bus_synced), 0);
    repeat (12) @(posedge hclk);
    #1;
    chk(32'(bus_synced), 1);
    rd(`CMC_OFF_MODE, 8'hC0);
    wr(`CMC_OFF_MODE, 8'h00);
    rd(`CMC_OFF_MODE, 8'hC0);
    wr(`CMC_OFF_BTA, 8'h11);
    rd(`CMC_OFF_BTA, 8'h5A);
    engine_tx_bit <= 1'b0;
    @(posedge hclk);
    #1;
    chk(32'(bus_tx_pin), 0);
    cpu_stop <= 1'b1;
    @(posedge hclk);
    #1;
    chk(32'(bus_tx_pin), 1);
    cpu_stop <= 1'b0;
    rx_frame_busy <= 1'b1;
    wr(`CMC_OFF_RIER, 8'h80);
    wr(`CMC_OFF_CTL0, 8'h06);
    wr(`CMC_OFF_CTL0, 8'h04);
    rd(`CMC_OFF_CTL0, 8'h16);
    rd(`CMC_OFF_MODE, 8'hC0);
    rx_frame_busy <= 1'b0;
    repeat (2) @(posedge hclk);
    rd(`CMC_OFF_MODE, 8'hC2);
    chk(32'(bus_tx_pin), 1);
    dom <= 1'b1;
    @(posedge hclk);
    #1;
    dom <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(`CMC_OFF_MODE, 8'hC0);
    rd(`CMC_OFF_RFLG, 8'h88);
    wr(`CMC_OFF_RFLG, 8'h80);
    rd(`CMC_OFF_RIER, 8'h80);
    wr(`CMC_OFF_CTL0, 8'h06);
    repeat (2) @(posedge hclk);
    rd(`CMC_OFF_MODE, 8'hC2);
    wr(`CMC_OFF_CTL0, 8'h25);
    chk(32'(bus_tx_pin), 1);
    rd(`CMC_OFF_CTL0, 8'h05);
    rd(`CMC_OFF_RFLG, 8'h08);
    rd(`CMC_OFF_RIER, 8'h00);
    wr(`CMC_OFF_MODE, 8'hC4);
    wr(`CMC_OFF_CTL0, 8'h04);
    wr(`CMC_OFF_CTL0, 8'h06);
    dom <= 1'b1;
    repeat (8) @(posedge hclk);
    dom <= 1'b0;
    rd(`CMC_OFF_MODE, 8'hC6);
    dom <= 1'b1;
    repeat (510) @(posedge hclk);
    dom <= 1'b0;
    rd(`CMC_OFF_MODE, 8'hC4);
    conclude();
  end
endmodule
`default_nettype wire
